//--- verilog/tdm_rate_pkg.sv
// shared constants, register map and carrier types for the serial rate configuration block
package tdm_rate_pkg;

    // register map, byte addresses
    localparam logic [7:0] MODE_OFFSET   = 8'h00;
    localparam logic [7:0] PAIR_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] CONFIG_OFFSET = 8'h0C;

    // interface_mode_register layout (low byte)
    localparam int MODE_SCB_POS  = 0;
    localparam int MODE_IDR_POS  = 2;
    localparam int MODE_ODR_POS  = 4;
    localparam int MODE_CLKR_POS = 6;
    localparam int MODE_MAIN_POS = 7;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // pair_select_register layout: pair A low nibble, pair B high nibble
    localparam int PAIR_A_POS = 0;
    localparam int PAIR_B_POS = 4;
    localparam logic [7:0] PAIR_RESET = 8'h32;
    localparam logic [3:0] PAIR_MIN   = 4'h2;
    localparam logic [3:0] PAIR_MAX   = 4'h9;

    // rate codes in the rate fields
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;

    // arrangement codes at 2.048 Mb/s identical rates
    localparam logic [1:0] ARR_8X8    = 2'h0;
    localparam logic [1:0] ARR_16X8   = 2'h1;
    localparam logic [1:0] ARR_PAIRS  = 2'h2;
    localparam logic [1:0] ARR_NIBBLE = 2'h3;
    // arrangement codes at 4.096 Mb/s identical rates
    localparam logic [1:0] ARR_4M_8X4 = 2'h0;
    localparam logic [1:0] ARR_4M_4X4 = 2'h1;

    // frame timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int FRAME_NS         = 125000;
    localparam int FRAME_CYCLES     = FRAME_NS / CLK_PERIOD_NS;
    localparam int LOSS_CYCLES      = 2 * FRAME_CYCLES;
    localparam int PULSE_MAX_CYCLES = FRAME_CYCLES / 4;
    localparam int TIMER_W          = 12;

    typedef struct packed {
        logic       main_operation_select;
        logic       clock_ratio_select;
        logic [1:0] output_rate_bits;
        logic [1:0] input_rate_bits;
        logic [1:0] switch_config_field;
    } mode_t;

    typedef struct packed {
        logic [7:0] channels;
        logic [4:0] in_streams;
        logic [3:0] out_streams;
        logic       nonblocking;
        logic       const_delay_ok;
        logic       nibble;
        logic       pair_mode;
        logic       valid;
    } config_t;

    typedef struct packed {
        logic tx_rising;
        logic sample_rising;
        logic two_clocks_per_bit;
    } edge_t;

endpackage

//--- verilog/tdm_serial_rate_config.sv
// serial rate, edge and switching arrangement selection for a time-slot interchange switch
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps

module tdm_serial_rate_config #(
    parameter int IN_PINS  = 16,
    parameter int OUT_PINS = 10
) (
    input  wire logic                    clock,
    input  wire logic                    resetn,
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic [31:0]                  rdata,
    input  wire logic                    frame_pulse_in,
    input  wire logic                    mux_bus_mode,
    output tdm_rate_pkg::config_t        active_config,
    output tdm_rate_pkg::edge_t          input_edges,
    output tdm_rate_pkg::edge_t          output_edges,
    output logic [IN_PINS-1:0]           in_stream_enable,
    output logic [OUT_PINS-1:0]          out_stream_enable,
    output logic                         link_clock_8m,
    output logic                         frame_present
);

    if (IN_PINS != 16 || OUT_PINS != 10)
    begin : g_bad_pins
        $error("stream pin counts must be 16 inputs and 10 outputs");
    end

    // host registers
    tdm_rate_pkg::mode_t mode_q;
    logic [7:0]          pair_q;
    logic [31:0]         rdata_q;


    wire logic wr_mode = wr && (addr == tdm_rate_pkg::MODE_OFFSET);
    wire logic wr_pair = wr && (addr == tdm_rate_pkg::PAIR_OFFSET);

    // mode stays at reset until the host writes it
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= tdm_rate_pkg::MODE_RESET;
            pair_q <= tdm_rate_pkg::PAIR_RESET;
        end
        else
        begin
            if (wr_mode)
                mode_q <= tdm_rate_pkg::mode_t'(wdata[7:0]);
            if (wr_pair)
                pair_q <= wdata[7:0];
        end
    end

    wire logic [3:0] pair_a = pair_q[tdm_rate_pkg::PAIR_A_POS +: 4];
    wire logic [3:0] pair_b = pair_q[tdm_rate_pkg::PAIR_B_POS +: 4];

    // frame pulse watcher
    logic                             fr_q;
    logic                             fr_seen_q;
    logic                             polarity_q;
    logic                             present_q;
    logic [tdm_rate_pkg::TIMER_W-1:0] level_cnt_q;
    logic [tdm_rate_pkg::TIMER_W-1:0] quiet_cnt_q;

    localparam logic [tdm_rate_pkg::TIMER_W-1:0] PULSE_MAX =
        tdm_rate_pkg::TIMER_W'(tdm_rate_pkg::PULSE_MAX_CYCLES);
    localparam logic [tdm_rate_pkg::TIMER_W-1:0] LOSS_MAX =
        tdm_rate_pkg::TIMER_W'(tdm_rate_pkg::LOSS_CYCLES);

    // counters hold at loss limit
    wire logic fr_edge      = fr_seen_q && (frame_pulse_in != fr_q);
    // short level just ended means that level was the pulse
    wire logic pulse_ended  = fr_edge && (level_cnt_q < PULSE_MAX);
    wire logic quiet_expire = (quiet_cnt_q == LOSS_MAX);

    // presence and polarity found from the pulse width
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            fr_q        <= 1'b0;
            fr_seen_q   <= 1'b0;
            polarity_q  <= 1'b0;
            present_q   <= 1'b0;
            level_cnt_q <= '0;
            quiet_cnt_q <= '0;
        end
        else
        begin
            fr_q      <= frame_pulse_in;
            fr_seen_q <= 1'b1;
            if (fr_edge)
                level_cnt_q <= '0;
            else if (level_cnt_q != LOSS_MAX)
                level_cnt_q <= level_cnt_q + 1'b1;
            if (pulse_ended)
            begin
                polarity_q  <= fr_q;
                present_q   <= 1'b1;
                quiet_cnt_q <= '0;
            end
            else if (quiet_expire)
                present_q <= 1'b0;
            else
                quiet_cnt_q <= quiet_cnt_q + 1'b1;
        end
    end

    // decode of the arrangement, used once for the live mode
    function automatic tdm_rate_pkg::config_t decode_config(
        input tdm_rate_pkg::mode_t m,
        input logic                mux_mode,
        input logic                pairs_ok
    );
        tdm_rate_pkg::config_t c;

        c = '0;
        if (!m.main_operation_select)
        begin
            // identical rates: output rate bits ignored
            unique case (m.input_rate_bits)
                tdm_rate_pkg::RATE_2M:
                begin
                    c.channels = 8'h20;
                    unique case (m.switch_config_field)
                        tdm_rate_pkg::ARR_8X8:
                        begin
                            c.in_streams     = 5'h08;
                            c.out_streams    = 4'h8;
                            c.nonblocking    = 1'b1;
                            c.const_delay_ok = 1'b1;
                            c.valid          = 1'b1;
                        end
                        tdm_rate_pkg::ARR_16X8:
                        begin
                            c.in_streams = 5'h10;
                            c.out_streams = 4'h8;
                            c.valid      = mux_mode;
                        end
                        tdm_rate_pkg::ARR_PAIRS:
                        begin
                            c.in_streams     = 5'h04;
                            c.out_streams    = 4'h4;
                            c.nonblocking    = 1'b1;
                            c.const_delay_ok = 1'b1;
                            c.pair_mode      = 1'b1;
                            c.valid          = pairs_ok;
                        end
                        tdm_rate_pkg::ARR_NIBBLE:
                        begin
                            // 8 in, 4 out nibble matrix
                            c.channels    = 8'h40;
                            c.in_streams  = 5'h08;
                            c.out_streams = 4'h4;
                            c.nibble      = 1'b1;
                            c.valid       = 1'b1;
                        end
                    endcase
                end
                tdm_rate_pkg::RATE_4M:
                begin
                    c.channels = 8'h40;
                    if (m.switch_config_field == tdm_rate_pkg::ARR_4M_8X4)
                    begin
                        c.in_streams  = 5'h08;
                        c.out_streams = 4'h4;
                        c.valid       = 1'b1;
                    end
                    else if (m.switch_config_field == tdm_rate_pkg::ARR_4M_4X4)
                    begin
                        c.in_streams     = 5'h04;
                        c.out_streams    = 4'h4;
                        c.nonblocking    = 1'b1;
                        c.const_delay_ok = 1'b1;
                        c.valid          = 1'b1;
                    end
                end
                tdm_rate_pkg::RATE_8M:
                begin
                    c.channels       = 8'h80;
                    c.in_streams     = 5'h02;
                    c.out_streams    = 4'h2;
                    c.nonblocking    = 1'b1;
                    c.const_delay_ok = 1'b1;
                    c.valid          = 1'b1;
                end
                default:
                    c = '0;
            endcase
        end
        else
        begin
            c.nonblocking    = 1'b1;
            c.const_delay_ok = 1'b1;
            c.channels       = 8'h20;
            unique case ({m.input_rate_bits, m.output_rate_bits})
                {tdm_rate_pkg::RATE_2M, tdm_rate_pkg::RATE_4M}:
                begin
                    c.in_streams  = 5'h08;
                    c.out_streams = 4'h4;
                    c.valid       = 1'b1;
                end
                {tdm_rate_pkg::RATE_2M, tdm_rate_pkg::RATE_8M}:
                begin
                    c.in_streams  = 5'h08;
                    c.out_streams = 4'h2;
                    c.valid       = 1'b1;
                end
                {tdm_rate_pkg::RATE_4M, tdm_rate_pkg::RATE_2M}:
                begin
                    c.in_streams  = 5'h04;
                    c.out_streams = 4'h8;
                    c.valid       = 1'b1;
                end
                {tdm_rate_pkg::RATE_8M, tdm_rate_pkg::RATE_2M}:
                begin
                    c.in_streams  = 5'h02;
                    c.out_streams = 4'h8;
                    c.valid       = 1'b1;
                end
                default:
                    c = '0;
            endcase
        end
        return c;
    endfunction

    // edge choice for one side of the link
    function automatic tdm_rate_pkg::edge_t side_edges(
        input logic slow_side,
        input logic positive_pulse,
        input logic two_clocks
    );
        tdm_rate_pkg::edge_t e;

        // negative pulse: bound on falling, sample rising
        // positive pulse GCI: bound on rising, sample falling
        // fast side: positive transmits rising, negative swaps
        e.tx_rising          = positive_pulse;
        e.sample_rising      = !positive_pulse;
        e.two_clocks_per_bit = slow_side && two_clocks;
        return e;
    endfunction

    wire logic pairs_ok = (pair_a >= tdm_rate_pkg::PAIR_MIN) && (pair_a <= tdm_rate_pkg::PAIR_MAX)
                       && (pair_b >= tdm_rate_pkg::PAIR_MIN) && (pair_b <= tdm_rate_pkg::PAIR_MAX)
                       && (pair_a != pair_b);

    wire tdm_rate_pkg::config_t cfg_d = decode_config(mode_q, mux_bus_mode, pairs_ok);

    // one rate per direction, identical mode reuses the input rate
    wire logic [1:0] in_rate  = mode_q.input_rate_bits;
    wire logic [1:0] out_rate = mode_q.main_operation_select ? mode_q.output_rate_bits
                                                              : mode_q.input_rate_bits;

    wire logic in_slow  = (in_rate == tdm_rate_pkg::RATE_2M);
    wire logic out_slow = (out_rate == tdm_rate_pkg::RATE_2M);

    // ratio bit only steers identical rates
    wire logic two_clocks = mode_q.main_operation_select || !mode_q.clock_ratio_select;
    wire logic ratio_bad  = !mode_q.main_operation_select
                         && (mode_q.clock_ratio_select == in_slow);

    // each side picks its own edge rule
    wire tdm_rate_pkg::edge_t in_edges_d  = side_edges(in_slow, polarity_q, two_clocks);
    wire tdm_rate_pkg::edge_t out_edges_d = side_edges(out_slow, polarity_q, two_clocks);

    // 8.192 MHz link clock whenever either side runs at 8.192
    wire logic clk8_d = (in_rate == tdm_rate_pkg::RATE_8M) || (out_rate == tdm_rate_pkg::RATE_8M);

    // stream enables; pair mode maps A and B onto pins 2..9
    logic [IN_PINS-1:0]  in_en_d;
    logic [OUT_PINS-1:0] out_en_d;

    for (genvar i = 0; i < IN_PINS; i++)
    begin : g_in_en
        // pairs 0 and 1 fixed, A and B selectable
        assign in_en_d[i] = cfg_d.valid && (cfg_d.pair_mode
            ? (i < 2 || pair_a == 4'(i) || pair_b == 4'(i))
            : (i < int'(cfg_d.in_streams)));
    end

    for (genvar j = 0; j < OUT_PINS; j++)
    begin : g_out_en
        assign out_en_d[j] = cfg_d.valid && (cfg_d.pair_mode
            ? (j < 2 || pair_a == 4'(j) || pair_b == 4'(j))
            : (j < int'(cfg_d.out_streams)));
    end

    // registered outputs; no edges are reported until a pulse is seen
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            active_config     <= '0;
            input_edges       <= '0;
            output_edges      <= '0;
            in_stream_enable  <= '0;
            out_stream_enable <= '0;
            link_clock_8m     <= 1'b0;
        end
        else
        begin
            active_config     <= cfg_d;
            input_edges       <= present_q ? in_edges_d : '0;
            output_edges      <= present_q ? out_edges_d : '0;
            in_stream_enable  <= in_en_d;
            out_stream_enable <= out_en_d;
            link_clock_8m     <= clk8_d;
        end
    end

    assign frame_present = present_q;

    // read mux
    wire logic [31:0] status_word = {24'h000000, mux_bus_mode, !pairs_ok, clk8_d, ratio_bad,
                                     cfg_d.valid, polarity_q, polarity_q, present_q};
    // in [4:0], out [11:8]
    wire logic [31:0] config_word = {cfg_d.channels, 4'h0, cfg_d.pair_mode, cfg_d.nibble,
                                     cfg_d.const_delay_ok, cfg_d.nonblocking, 4'h0,
                                     cfg_d.out_streams, 3'h0, cfg_d.in_streams};
    wire logic [31:0] read_sel =
        (addr == tdm_rate_pkg::MODE_OFFSET)   ? {24'h000000, mode_q} :
        (addr == tdm_rate_pkg::PAIR_OFFSET)   ? {24'h000000, pair_q} :
        (addr == tdm_rate_pkg::STATUS_OFFSET) ? status_word :
        (addr == tdm_rate_pkg::CONFIG_OFFSET) ? config_word : 32'h00000000;

    // data held for one cycle only, zero otherwise
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rd ? read_sel : 32'h00000000;
    end

    assign rdata = rdata_q;

endmodule // tdm_serial_rate_config

//--- tb/frame_source.sv
// frame pulse source standing in for the serial backbone
`timescale 1ns/1ps

module frame_source #(
    parameter int PERIOD = 1250
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic       positive,
    input  wire logic [8:0] width,
    output logic            frame_pulse_in
);
    int count_q;

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            count_q <= 0;
        else
            count_q <= (count_q == PERIOD - 1) ? 0 : count_q + 1;

    // 8 kHz pulse
    // idle level is the inverse polarity so the line never floats to a guess
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            frame_pulse_in <= !positive;
        else
            frame_pulse_in <= (run && count_q < int'(width)) ? positive : !positive;
endmodule // frame_source

//--- tb/serial_rate_asserts.sv
// port-level assertions for the serial rate configuration block
`timescale 1ns/1ps

module serial_rate_asserts #(
    parameter int IN_PINS  = 16,
    parameter int OUT_PINS = 10
) (
    input wire logic                  clock,
    input wire logic                  resetn,
    input wire logic [7:0]            addr,
    input wire logic [31:0]           wdata,
    input wire logic                  wr,
    input wire logic                  rd,
    input wire logic [31:0]           rdata,
    input wire logic                  frame_pulse_in,
    input wire logic                  mux_bus_mode,
    input wire tdm_rate_pkg::config_t active_config,
    input wire tdm_rate_pkg::edge_t   input_edges,
    input wire tdm_rate_pkg::edge_t   output_edges,
    input wire logic [IN_PINS-1:0]    in_stream_enable,
    input wire logic [OUT_PINS-1:0]   out_stream_enable,
    input wire logic                  link_clock_8m,
    input wire logic                  frame_present
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_read_quiet;
        rdata != 32'h0 |-> $past(rd);
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read data outside read slot");

    property p_idle_edges;
        !frame_present && !$past(frame_present) |-> input_edges == 3'h0 && output_edges == 3'h0;
    endproperty
    a_idle_edges: assert property (p_idle_edges) else $error("edges set without frame");

    property p_edge_sense;
        frame_present && $past(frame_present) |-> input_edges.tx_rising != input_edges.sample_rising;
    endproperty
    a_edge_sense: assert property (p_edge_sense) else $error("transmit and sample share edge");

    property p_same_sense;
        frame_present && $past(frame_present) |-> output_edges.tx_rising == input_edges.tx_rising;
    endproperty
    a_same_sense: assert property (p_same_sense) else $error("sides disagree on polarity");

    property p_fast_clock;
        active_config.valid && active_config.in_streams == 5'd2 |-> link_clock_8m;
    endproperty
    a_fast_clock: assert property (p_fast_clock) else $error("8.192 input without fast clock");

    property p_const_nb;
        active_config.valid && active_config.const_delay_ok |-> active_config.nonblocking;
    endproperty
    a_const_nb: assert property (p_const_nb) else $error("constant delay on blocking matrix");

    property p_nibble;
        active_config.valid && active_config.nibble |-> !active_config.const_delay_ok
            && active_config.channels == 8'h40 && $countones(out_stream_enable) == 4;
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble arrangement wrong");

    property p_pair_pins;
        active_config.valid && active_config.pair_mode |-> in_stream_enable[1:0] == 2'h3
            && $countones(in_stream_enable) == 4;
    endproperty
    a_pair_pins: assert property (p_pair_pins) else $error("pair mode pins wrong");

    property p_invalid_off;
        !active_config.valid |-> in_stream_enable == '0 && out_stream_enable == '0;
    endproperty
    a_invalid_off: assert property (p_invalid_off) else $error("streams on when invalid");

    property p_mux_only;
        active_config.valid && active_config.in_streams == 5'd16
            |-> $past(mux_bus_mode) || $past(mux_bus_mode, 2);
    endproperty
    a_mux_only: assert property (p_mux_only) else $error("16x8 without mux bus");

    property p_eight_meg;
        active_config.valid && active_config.in_streams == 5'd2 && active_config.out_streams == 4'd2
            |-> active_config.channels == 8'h80 && active_config.nonblocking;
    endproperty
    a_eight_meg: assert property (p_eight_meg) else $error("8.192 arrangement wrong");
endmodule // serial_rate_asserts

bind tdm_serial_rate_config serial_rate_asserts #(.IN_PINS(IN_PINS), .OUT_PINS(OUT_PINS)) chk (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .frame_pulse_in(frame_pulse_in), .mux_bus_mode(mux_bus_mode),
    .active_config(active_config), .input_edges(input_edges), .output_edges(output_edges),
    .in_stream_enable(in_stream_enable), .out_stream_enable(out_stream_enable),
    .link_clock_8m(link_clock_8m), .frame_present(frame_present));

//--- tb/tb.sv
// self-checking bench for the serial rate configuration block
`timescale 1ns/1ps

module tb;
    logic                  clock = 1'b0;
    logic                  resetn = 1'b0;
    logic [7:0]            addr = 8'h00;
    logic [31:0]           wdata = 32'h0;
    logic                  wr = 1'b0;
    logic                  rd = 1'b0;
    logic                  mux_bus_mode = 1'b0;
    logic                  run = 1'b0;
    logic                  positive = 1'b1;
    logic                  frame_pulse_in;
    logic [31:0]           rdata;
    tdm_rate_pkg::config_t active_config, e_cfg;
    tdm_rate_pkg::edge_t   input_edges, output_edges;
    logic [15:0]           in_stream_enable, e_in;
    logic [9:0]            out_stream_enable, e_out;
    logic                  link_clock_8m, frame_present, e_ok, e_8m, e_bad;
    logic [7:0]            mode = 8'h00, pair = 8'h32;
    logic [7:0]            modes[7] = '{8'h00, 8'h45, 8'h48, 8'h90, 8'h88, 8'hA0, 8'h84};
    logic [7:0]            pairs[4] = '{8'h55, 8'hA2, 8'h91, 8'h29};
    int                    num_errors = 0, n_checks = 0, seed = 32'hca4527a8, r;

    always #50 clock = ~clock;

    frame_source src (.clock(clock), .resetn(resetn), .run(run), .positive(positive),
        .width(9'd5), .frame_pulse_in(frame_pulse_in));

    tdm_serial_rate_config dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .frame_pulse_in(frame_pulse_in),
        .mux_bus_mode(mux_bus_mode), .active_config(active_config), .input_edges(input_edges),
        .output_edges(output_edges), .in_stream_enable(in_stream_enable),
        .out_stream_enable(out_stream_enable), .link_clock_8m(link_clock_8m),
        .frame_present(frame_present));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // upper write bits are random: the block must ignore them
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= ($random(seed) & 32'hFFFFFF00) | {24'h0, d};
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk("read data", e & m, rdata & m);
    endtask

    task automatic model();
        int ir, orr, sc, ni, no, ch, pa, pb;
        logic nb, cd, nib, pm;
        ir = mode[3:2];
        orr = mode[5:4];
        sc = mode[1:0];
        pa = pair[3:0];
        pb = pair[7:4];
        e_bad = !(pa >= 2 && pa <= 9 && pb >= 2 && pb <= 9 && pa != pb);
        {nb, cd, nib, pm, e_ok, ch} = {5'b11001, 32'd32};
        if (mode[7])
        begin
            ni = ir == 0 ? 8 : ir == 1 ? 4 : 2;
            no = orr == 0 ? 8 : orr == 1 ? 4 : 2;
            e_ok = (ir == 0) != (orr == 0) && ir != 3 && orr != 3;
        end
        else if (ir == 0)
        begin
            ni = sc == 1 ? 16 : sc == 2 ? 4 : 8;
            no = sc < 2 ? 8 : 4;
            pm = sc == 2;
            nib = sc == 3;
            nb = sc == 0 || sc == 2;
            cd = nb;
            ch = nib ? 64 : 32;
            e_ok = sc == 1 ? mux_bus_mode : sc == 2 ? !e_bad : 1'b1;
        end
        else if (ir == 1)
        begin
            {ch, ni, no, nb, cd, e_ok} = {32'd64, sc == 0 ? 8 : 4, 32'd4, sc == 1, sc == 1, sc < 2};
        end
        else
        begin
            {ch, ni, no, e_ok} = {32'd128, 32'd2, 32'd2, ir == 2};
        end
        e_8m = ir == 2 || (mode[7] && orr == 2);
        e_cfg = {8'(ch), 5'(ni), 4'(no), nb, cd, nib, pm, 1'b1};
        e_in = pm ? 16'h3 | (16'h1 << pa) | (16'h1 << pb) : 16'((1 << ni) - 1);
        e_out = pm ? 10'h3 | (10'h1 << pa) | (10'h1 << pb) : 10'((1 << no) - 1);
        if (!e_ok)
            {e_in, e_out} = 26'h0;
    endtask

    task automatic check_all();
        model();
        chk("valid", 32'(e_ok), 32'(active_config.valid));
        chk("in enables", 32'(e_in), 32'(in_stream_enable));
        chk("out enables", 32'(e_out), 32'(out_stream_enable));
        if (e_ok)
        begin
            chk("config", 32'(e_cfg), 32'(active_config));
            chk("clock 8m", 32'(e_8m), 32'(link_clock_8m));
        end
    endtask

    task automatic set_mode(input logic [7:0] m);
        mode = m;
        wr_reg(tdm_rate_pkg::MODE_OFFSET, m);
        repeat (3) @(posedge clock);
        #1 check_all();
    endtask

    task automatic check_edges();
        logic s2i, s2o;
        s2i = mode[3:2] == 2'h0 && (mode[7] || !mode[6]);
        s2o = mode[7] ? mode[5:4] == 2'h0 : s2i;
        chk("present", 32'h1, 32'(frame_present));
        chk("in edges", 32'({positive, !positive, s2i}), 32'(input_edges));
        chk("out edges", 32'({positive, !positive, s2o}), 32'(output_edges));
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #5000000;
        num_errors++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge clock);
        chk("config in reset", 32'h0, 32'(active_config));
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        #1 check_all();
        rd_reg(tdm_rate_pkg::MODE_OFFSET, 32'h0, 32'hFF);
        rd_reg(tdm_rate_pkg::PAIR_OFFSET, 32'h32, 32'hFF);
        rd_reg(8'h10, 32'h0, 32'hFFFFFFFF);
        wr_reg(tdm_rate_pkg::STATUS_OFFSET, 8'hFF);
        wr_reg(tdm_rate_pkg::CONFIG_OFFSET, 8'hFF);
        rd_reg(tdm_rate_pkg::MODE_OFFSET, 32'h0, 32'hFF);
        set_mode(8'h01);
        @(posedge clock) mux_bus_mode <= 1'b1;
        set_mode(8'h01);
        set_mode(8'h02);
        foreach (pairs[i])
        begin
            pair = pairs[i];
            wr_reg(tdm_rate_pkg::PAIR_OFFSET, pairs[i]);
            repeat (3) @(posedge clock);
            #1 check_all();
        end
        // nibble arrangement: 8 inputs, 4 outputs
        set_mode(8'h03);
        for (int k = 0; k < 2; k++)
        begin
            positive <= (k == 0);
            run <= 1'b1;
            repeat (1300) @(posedge clock);
            foreach (modes[i])
            begin
                set_mode(modes[i]);
                check_edges();
            end
        end
        run <= 1'b0;
        repeat (2600) @(posedge clock);
        #1 chk("lost frame", 32'h0, 32'({frame_present, input_edges, output_edges}));
        for (int i = 0; i < 40; i++)
        begin
            r = $random(seed);
            @(posedge clock) mux_bus_mode <= r[8];
            set_mode(r[7:0]);
            rd_reg(tdm_rate_pkg::MODE_OFFSET, 32'(mode), 32'hFF);
            rd_reg(tdm_rate_pkg::STATUS_OFFSET, 32'({mux_bus_mode, e_bad, e_8m,
                !mode[7] && ((mode[3:2] == 2'h0) == mode[6]), e_ok, 3'h0}),
                e_ok && !mode[7] ? 32'hF8 : 32'hC8);
        end
        @(posedge clock);
        resetn <= 1'b0;
        mode = 8'h00;
        pair = 8'h32;
        @(posedge clock);
        #1 chk("config mid reset", 32'h0, 32'(active_config));
        @(posedge clock);
        resetn <= 1'b1;
        rd_reg(tdm_rate_pkg::PAIR_OFFSET, 32'h32, 32'hFF);
        #1 check_all();
        final_report();
    end
endmodule // tb
